// ===== common/psc_defs.svh
// timing figures, register offsets and reset values of the scan-cycle sequencer
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

// ----------------------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------------------
`define PSC_CLK_NS      5
`define PSC_TICK_NS     10000
`define PSC_TICK_CYC    11'((`PSC_TICK_NS) / (`PSC_CLK_NS))
`define PSC_US2TK(us)   16'(((us) * 1000) / (`PSC_TICK_NS))

// ----------------------------------------------------------------------------
// phase durations in microseconds, and the cycle-time divisor for the service budget
// ----------------------------------------------------------------------------
`define PSC_OVR_FAST_US   130
`define PSC_OVR_MID_US    300
`define PSC_OVR_SLOW_US   500
`define PSC_OVR_PULSE_US  600
`define PSC_POVR_FAST_US  280
`define PSC_POVR_MID_US   300
`define PSC_LOVR_FAST_US  180
`define PSC_LOVR_MID_US   200
`define PSC_SVC_MIN_US    100
`define PSC_SLOT_US       1000
`define PSC_EXT_US        10000
`define PSC_PCT_DIV       20'd25

// ----------------------------------------------------------------------------
// service classes and counts
// ----------------------------------------------------------------------------
`define PSC_NCLS          6
`define PSC_CLS_END       3'd6
`define PSC_CLS_FILE      3'd4
`define PSC_IO_CLS_END    2'd3

// ----------------------------------------------------------------------------
// register byte offsets and reset values
// ----------------------------------------------------------------------------
`define PSC_REG_CTRL      6'h00
`define PSC_REG_FIXED     6'h04
`define PSC_REG_UNIFORM   6'h08
`define PSC_REG_LIMIT     6'h0c
`define PSC_REG_UCNT      6'h10
`define PSC_REG_UTIME     6'h14
`define PSC_REG_STATUS    6'h18
`define PSC_REG_PLOOP     6'h1c
`define PSC_REG_EXEC      6'h20
`define PSC_CTRL_RST      8'h00
`define PSC_FIXED_RST     16'h0000
`define PSC_UNIFORM_RST   16'h0000
`define PSC_LIMIT_RST     16'hffff
`define PSC_UNIT_RST      24'h000000

`endif

// ===== common/psc_pkg.sv
// types shared by the scan-cycle sequencer
package psc_pkg;

  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } psc_bus_req_t;

  typedef struct packed {
    logic       enable;
    logic [1:0] variant;
    logic       pulse_io;
    logic       run_mode;
    logic       uniform_en;
    logic       fixed_en;
    logic       parallel;
  } psc_ctrl_t;

  typedef struct packed {
    logic       out_stb;
    logic       in_stb;
    logic [1:0] cls;
    logic [7:0] unit;
  } psc_io_t;

  typedef enum logic [1:0] {
    PSC_VAR_FAST  = 2'h0,
    PSC_VAR_MID   = 2'h1,
    PSC_VAR_PULSE = 2'h2,
    PSC_VAR_BASE  = 2'h3
  } psc_variant_t;

  typedef enum logic [5:0] {
    M_IDLE = 6'h01,
    M_OVER = 6'h02,
    M_EXEC = 6'h04,
    M_CALC = 6'h08,
    M_IO   = 6'h10,
    M_SVC  = 6'h20
  } psc_main_t;

  typedef enum logic [2:0] {
    P_IDLE = 3'h1,
    P_OVER = 3'h2,
    P_SVC  = 3'h4
  } psc_ploop_t;

endpackage

// ===== src/psc_scan_seq.sv
// scan-cycle sequencer with phase time budgets, normal and parallel modes
`timescale 1ns/1ps
`include "psc_defs.svh"

module psc_scan_seq (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire psc_pkg::psc_bus_req_t bus_req,
  output logic [31:0]               rdata,
  output logic                      prog_start,
  input  wire logic                 prog_done,
  output psc_pkg::psc_io_t          io,
  input  wire logic [5:0]           svc_present,
  input  wire logic [5:0]           svc_done,
  output logic [5:0]                svc_grant,
  output logic                      cycle_end
);
  import psc_pkg::*;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [19:0] sat_sub(input logic [19:0] a, input logic [19:0] b);
    return (a > b) ? 20'(a - b) : 20'h00000;
  endfunction

  function automatic logic [15:0] budget(input logic present, input logic uen,
                                         input logic [15:0] ut, input logic [15:0] pct);
    logic [15:0] b;
    b = uen ? ut : pct;
    if (!present) begin
      return 16'h0000;
    end
    return (b < `PSC_US2TK(`PSC_SVC_MIN_US)) ? `PSC_US2TK(`PSC_SVC_MIN_US) : b;
  endfunction

  function automatic logic [15:0] oversee(input psc_ctrl_t c);
    if (c.parallel) begin
      return (c.variant == PSC_VAR_FAST) ? `PSC_US2TK(`PSC_POVR_FAST_US)
                                         : `PSC_US2TK(`PSC_POVR_MID_US);
    end
    unique case (c.variant)
      PSC_VAR_FAST:  return `PSC_US2TK(`PSC_OVR_FAST_US);
      PSC_VAR_MID:   return `PSC_US2TK(`PSC_OVR_MID_US);
      PSC_VAR_PULSE: return c.pulse_io ? `PSC_US2TK(`PSC_OVR_PULSE_US)
                                       : `PSC_US2TK(`PSC_OVR_SLOW_US);
      PSC_VAR_BASE:  return `PSC_US2TK(`PSC_OVR_SLOW_US);
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // registers and state
  // --------------------------------------------------------------------------
  psc_ctrl_t     ctrl_r;
  logic [15:0]   fixed_r;
  logic [15:0]   uniform_r;
  logic [15:0]   limit_r;
  logic [23:0]   ucnt_r;
  logic [23:0]   utime_r;
  logic          ext_pend_r;
  logic [31:0]   rdata_r;
  logic [10:0]   pre_r;
  logic          tick;
  psc_main_t     mstate_r;
  logic [19:0]   cnt_r;
  logic [19:0]   len_r;
  logic [19:0]   cyc_r;
  logic [15:0]   last_r;
  logic [15:0]   pct_r;
  logic [15:0]   exec_r;
  psc_io_t       io_r;
  logic          io_wait_r;
  logic [2:0]    scls_r;
  logic [5:0]    mgrant_r;
  logic          prog_start_r;
  logic          cyc_end_r;
  psc_ploop_t    pstate_r;
  logic [19:0]   pcnt_r;
  logic [19:0]   pcyc_r;
  logic [15:0]   plast_r;
  logic [2:0]    pcls_r;
  logic [5:0]    pgrant_r;
  logic [19:0]   refresh_est;
  logic [19:0]   svc_est;
  logic [19:0]   others;
  logic [19:0]   wait_fix;
  logic [19:0]   room;
  logic [19:0]   ext_len;
  logic [19:0]   calc_len;
  logic [15:0]   cur_bud;
  logic          ext_use;
  logic          run_rise;

  // --------------------------------------------------------------------------
  // register bus slave
  // --------------------------------------------------------------------------
  assign run_rise = bus_req.wr && (bus_req.addr == `PSC_REG_CTRL) && !ctrl_r.run_mode &&
                    bus_req.wdata[3];
  assign ext_use  = (mstate_r == M_EXEC) && prog_done;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r    <= psc_ctrl_t'(`PSC_CTRL_RST);
      fixed_r   <= `PSC_FIXED_RST;
      uniform_r <= `PSC_UNIFORM_RST;
      limit_r   <= `PSC_LIMIT_RST;
      ucnt_r    <= `PSC_UNIT_RST;
      utime_r   <= `PSC_UNIT_RST;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        `PSC_REG_CTRL:    ctrl_r    <= psc_ctrl_t'(bus_req.wdata[7:0]);
        `PSC_REG_FIXED:   fixed_r   <= bus_req.wdata[15:0];
        `PSC_REG_UNIFORM: uniform_r <= bus_req.wdata[15:0];
        `PSC_REG_LIMIT:   limit_r   <= bus_req.wdata[15:0];
        `PSC_REG_UCNT:    ucnt_r    <= bus_req.wdata[23:0];
        `PSC_REG_UTIME:   utime_r   <= bus_req.wdata[23:0];
        default: ;
      endcase
    end
  end

  // mode change flag: a new switch in the cycle of consumption is kept
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_pend_r <= 1'b0;
    end else if (run_rise) begin
      ext_pend_r <= 1'b1;
    end else if (ext_use) begin
      ext_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_r <= 32'h00000000;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        `PSC_REG_CTRL:    rdata_r <= {24'h000000, ctrl_r};
        `PSC_REG_FIXED:   rdata_r <= {16'h0000, fixed_r};
        `PSC_REG_UNIFORM: rdata_r <= {16'h0000, uniform_r};
        `PSC_REG_LIMIT:   rdata_r <= {16'h0000, limit_r};
        `PSC_REG_UCNT:    rdata_r <= {8'h00, ucnt_r};
        `PSC_REG_UTIME:   rdata_r <= {8'h00, utime_r};
        `PSC_REG_STATUS:  rdata_r <= {4'h0, ext_pend_r, pstate_r, mstate_r, 2'h0, last_r};
        `PSC_REG_PLOOP:   rdata_r <= {16'h0000, plast_r};
        `PSC_REG_EXEC:    rdata_r <= {16'h0000, exec_r};
        default:          rdata_r <= 32'h00000000;
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  // --------------------------------------------------------------------------
  // 10 us tick prescaler
  // --------------------------------------------------------------------------
  assign tick = (pre_r == 11'(`PSC_TICK_CYC - 11'd1));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre_r <= 11'h000;
    end else if (tick) begin
      pre_r <= 11'h000;
    end else begin
      pre_r <= 11'(pre_r + 11'h001);
    end
  end

  // --------------------------------------------------------------------------
  // calculation-phase length
  // --------------------------------------------------------------------------
  always_comb begin
    refresh_est = 20'h00000;
    svc_est     = 20'h00000;
    for (int c = 0; c < 3; c++) begin
      refresh_est = 20'(refresh_est + 20'(ucnt_r[8*c +: 8]) * 20'(utime_r[8*c +: 8]));
    end
    for (int k = 0; k < `PSC_NCLS; k++) begin
      if (!ctrl_r.parallel || (3'(k) == `PSC_CLS_FILE)) begin
        svc_est = 20'(svc_est + 20'(budget(svc_present[k], ctrl_r.uniform_en, uniform_r,
                                           pct_r)));
      end
    end
    others   = 20'(cyc_r + refresh_est + svc_est);
    wait_fix = ctrl_r.fixed_en ? sat_sub(20'(fixed_r), others) : 20'h00000;
    room     = sat_sub(20'(limit_r), 20'(others + wait_fix));
    ext_len  = (room < 20'(`PSC_US2TK(`PSC_EXT_US))) ? room : 20'(`PSC_US2TK(`PSC_EXT_US));
    calc_len = ext_pend_r ? 20'(wait_fix + ext_len) : wait_fix;
    cur_bud  = budget(svc_present[scls_r], ctrl_r.uniform_en, uniform_r, pct_r);
  end

  // --------------------------------------------------------------------------
  // program execution loop
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mstate_r     <= M_IDLE;
      cnt_r        <= 20'h00000;
      len_r        <= 20'h00000;
      cyc_r        <= 20'h00000;
      last_r       <= 16'h0000;
      pct_r        <= 16'h0000;
      exec_r       <= 16'h0000;
      io_r         <= '0;
      io_wait_r    <= 1'b0;
      scls_r       <= 3'h0;
      mgrant_r     <= 6'h00;
      prog_start_r <= 1'b0;
      cyc_end_r    <= 1'b0;
    end else begin
      prog_start_r <= 1'b0;
      cyc_end_r    <= 1'b0;
      io_r.out_stb <= 1'b0;
      io_r.in_stb  <= 1'b0;
      if (tick) begin
        cnt_r <= 20'(cnt_r + 20'h00001);
        cyc_r <= 20'(cyc_r + 20'h00001);
      end
      unique case (mstate_r)
        M_IDLE: begin
          if (ctrl_r.enable) begin
            mstate_r <= M_OVER;
            len_r    <= 20'(oversee(ctrl_r));
            cnt_r    <= 20'h00000;
            cyc_r    <= 20'h00000;
          end
        end
        M_OVER: begin
          if (cnt_r >= len_r) begin
            mstate_r     <= M_EXEC;
            prog_start_r <= 1'b1;
            cnt_r        <= 20'h00000;
          end
        end
        M_EXEC: begin
          // the executor reports done once the ready cyclic tasks have run
          if (prog_done) begin
            exec_r   <= 16'(cnt_r);
            mstate_r <= M_CALC;
            len_r    <= calc_len;
            cnt_r    <= 20'h00000;
          end
        end
        M_CALC: begin
          if (cnt_r >= len_r) begin
            mstate_r  <= M_IO;
            io_r.cls  <= 2'h0;
            io_r.unit <= 8'h00;
            io_wait_r <= 1'b0;
          end
        end
        M_IO: begin
          if (io_r.cls == `PSC_IO_CLS_END) begin
            mstate_r <= M_SVC;
            scls_r   <= 3'h0;
            cnt_r    <= 20'h00000;
          end else if (io_r.in_stb) begin
            // index moves on after the input strobe, so both strobes name one unit
            io_r.unit <= 8'(io_r.unit + 8'h01);
          end else if (io_r.unit >= ucnt_r[8*io_r.cls +: 8]) begin
            io_r.cls  <= 2'(io_r.cls + 2'h1);
            io_r.unit <= 8'h00;
          end else if (!io_wait_r) begin
            io_r.out_stb <= 1'b1;
            io_wait_r    <= 1'b1;
            cnt_r        <= 20'h00000;
          end else if (cnt_r >= 20'(utime_r[8*io_r.cls +: 8])) begin
            io_r.in_stb <= 1'b1;
            io_wait_r   <= 1'b0;
          end
        end
        M_SVC: begin
          if (scls_r == `PSC_CLS_END) begin
            last_r    <= 16'(cyc_r);
            pct_r     <= 16'(cyc_r / `PSC_PCT_DIV);
            cyc_end_r <= 1'b1;
            cyc_r     <= 20'h00000;
            cnt_r     <= 20'h00000;
            len_r     <= 20'(oversee(ctrl_r));
            mstate_r  <= ctrl_r.enable ? M_OVER : M_IDLE;
          end else if ((ctrl_r.parallel && (scls_r != `PSC_CLS_FILE)) ||
                       (cur_bud == 16'h0000) || (cnt_r >= 20'(cur_bud))) begin
            scls_r   <= 3'(scls_r + 3'h1);
            mgrant_r <= 6'h00;
            cnt_r    <= 20'h00000;
          end else begin
            mgrant_r <= 6'(6'h01 << scls_r);
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // peripheral servicing loop, parallel mode only, own timers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pstate_r <= P_IDLE;
      pcnt_r   <= 20'h00000;
      pcyc_r   <= 20'h00000;
      plast_r  <= 16'h0000;
      pcls_r   <= 3'h0;
      pgrant_r <= 6'h00;
    end else begin
      if (tick) begin
        pcnt_r <= 20'(pcnt_r + 20'h00001);
        pcyc_r <= 20'(pcyc_r + 20'h00001);
      end
      unique case (pstate_r)
        P_IDLE: begin
          if (ctrl_r.enable && ctrl_r.parallel) begin
            pstate_r <= P_OVER;
            pcnt_r   <= 20'h00000;
            pcyc_r   <= 20'h00000;
          end
        end
        P_OVER: begin
          if (pcnt_r >= ((ctrl_r.variant == PSC_VAR_FAST) ? 20'(`PSC_US2TK(`PSC_LOVR_FAST_US))
                                                          : 20'(`PSC_US2TK(`PSC_LOVR_MID_US)))) begin
            pstate_r <= P_SVC;
            pcls_r   <= 3'h0;
            pcnt_r   <= 20'h00000;
          end
        end
        P_SVC: begin
          if (pcls_r == `PSC_CLS_END) begin
            plast_r  <= 16'(pcyc_r);
            pcyc_r   <= 20'h00000;
            pcnt_r   <= 20'h00000;
            pstate_r <= (ctrl_r.enable && ctrl_r.parallel) ? P_OVER : P_IDLE;
          end else if ((pcls_r == `PSC_CLS_FILE) || !svc_present[pcls_r] ||
                       (pcnt_r >= 20'(`PSC_US2TK(`PSC_SLOT_US))) ||
                       (pgrant_r[pcls_r] && svc_done[pcls_r])) begin
            pcls_r   <= 3'(pcls_r + 3'h1);
            pgrant_r <= 6'h00;
            pcnt_r   <= 20'h00000;
          end else begin
            pgrant_r <= 6'(6'h01 << pcls_r);
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign rdata      = rdata_r;
  assign prog_start = prog_start_r;
  assign io         = io_r;
  assign svc_grant  = mgrant_r | pgrant_r;
  assign cycle_end  = cyc_end_r;

endmodule

// ===== tb/psc_scan_seq_assertions.sv
// concurrent checks on the scan-cycle sequencer ports
`timescale 1ns/1ps
`include "psc_defs.svh"
module psc_scan_seq_checker
  import psc_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst_b,
  input wire psc_pkg::psc_bus_req_t bus_req,
  input wire logic [31:0]           rdata,
  input wire logic                  prog_start,
  input wire logic                  prog_done,
  input wire psc_pkg::psc_io_t      io,
  input wire logic [5:0]            svc_present,
  input wire logic [5:0]            svc_done,
  input wire logic [5:0]            svc_grant,
  input wire logic                  cycle_end
);
  localparam int TK = `PSC_TICK_NS / `PSC_CLK_NS;
  localparam int MIN_CYC = 9 * TK;
  localparam int SLOT_CYC = 101 * TK;
  logic        par_r;
  logic        pend_r;
  logic [17:0] g0_cnt_r;
  logic [9:0]  outu_r;
  // ----------
  // helper state
  // ----------
  // mode as last written by software
  always_ff @(posedge clk) begin
    if (!rst_b)
      par_r <= 1'b0;
    else if (bus_req.wr && bus_req.addr == `PSC_REG_CTRL)
      par_r <= bus_req.wdata[0];
  end
  // an output transfer waits for its input transfer
  always_ff @(posedge clk) begin
    if (!rst_b)
      pend_r <= 1'b0;
    else if (io.out_stb)
      pend_r <= 1'b1;
    else if (io.in_stb)
      pend_r <= 1'b0;
  end
  // class and unit named by the last output transfer
  always_ff @(posedge clk) begin
    if (!rst_b)
      outu_r <= 10'h000;
    else if (io.out_stb)
      outu_r <= {io.cls, io.unit};
  end
  always_ff @(posedge clk) begin
    if (!rst_b || !svc_grant[0])
      g0_cnt_r <= '0;
    else
      g0_cnt_r <= g0_cnt_r + 18'h1;
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_grant_end;
    $fell(svc_grant[0]) && !par_r;
  endsequence
  sequence s_done_granted;
    par_r && svc_grant[0] && svc_done[0];
  endsequence
  io_order_a: assert property (io.in_stb |-> pend_r)
    else $error("input transfer without output first");
  io_pair_a: assert property (io.in_stb |-> {io.cls, io.unit} == outu_r)
    else $error("input transfer names another unit");
  grant_absent_a: assert property ((svc_grant & ~$past(svc_present)) == 6'h0)
    else $error("absent class granted");
  grant_excl_a: assert property ($onehot0(svc_grant & 6'h2f))
    else $error("two classes granted together");
  io_no_grant_a: assert property (!par_r && (io.out_stb || io.in_stb) |-> svc_grant == 6'h0)
    else $error("service during refresh");
  start_pulse_a: assert property (prog_start |-> !cycle_end ##1 !prog_start)
    else $error("program start not a single pulse");
  end_pulse_a: assert property (cycle_end |=> !cycle_end [*8])
    else $error("cycle end too close together");
  grant_min_a: assert property (s_grant_end |-> g0_cnt_r >= MIN_CYC)
    else $error("service grant shorter than minimum");
  slot_max_a: assert property (par_r && svc_grant[0] |-> g0_cnt_r <= SLOT_CYC)
    else $error("peripheral slot overran");
  early_end_a: assert property (s_done_granted |-> ##[1:4] !svc_grant[0])
    else $error("finished class kept its slot");
endmodule
bind psc_scan_seq psc_scan_seq_checker u_chk (.clk, .rst_b, .bus_req, .rdata, .prog_start,
  .prog_done, .io, .svc_present, .svc_done, .svc_grant, .cycle_end);

// ===== tb/psc_far_model.sv
// far-side model: program executor, unit counter and service responders
`timescale 1ns/1ps
module psc_far_model
  import psc_pkg::*;
#(
  parameter int EXEC_CYC = 50,
  parameter int SVC_CYC  = 100
)
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             prog_start,
  output logic                  prog_done,
  input  wire psc_pkg::psc_io_t io,
  input  wire logic [5:0]       svc_grant,
  output logic [5:0]            svc_done,
  output logic [7:0]            out_cnt,
  output logic [7:0]            in_cnt
);
  int exec_left;
  int svc_cyc;
  // ----------
  // responders
  // ----------
  // program runs a fixed time per start, then reports done
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      exec_left <= 0;
      prog_done <= 1'b0;
    end else begin
      prog_done <= (exec_left == 1);
      if (prog_start)
        exec_left <= EXEC_CYC;
      else if (exec_left > 0)
        exec_left <= exec_left - 1;
    end
  end
  // a granted class runs out of events after a while; done drops with grant
  always_ff @(posedge clk) begin
    if (!rst_b || svc_grant == 6'h0) begin
      svc_cyc  <= 0;
      svc_done <= 6'h0;
    end else begin
      svc_cyc  <= svc_cyc + 1;
      svc_done <= (svc_cyc >= SVC_CYC) ? svc_grant : 6'h0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_cnt <= 8'h0;
      in_cnt  <= 8'h0;
    end else begin
      out_cnt <= out_cnt + {7'h0, io.out_stb};
      in_cnt  <= in_cnt + {7'h0, io.in_stb};
    end
  end
endmodule

// ===== tb/psc_scan_seq_test.sv
// self-checking bench for the scan-cycle sequencer
`timescale 1ns/1ps
`include "psc_defs.svh"
module psc_scan_seq_test;
  import psc_pkg::*;
  localparam int TK = `PSC_TICK_NS / `PSC_CLK_NS;
  logic         clk;
  logic         rst_b;
  psc_bus_req_t bus_req;
  logic [31:0]  rdata;
  logic         prog_start;
  logic         prog_done;
  psc_io_t      io;
  logic [5:0]   svc_present;
  logic [5:0]   svc_done;
  logic [5:0]   svc_grant;
  logic         cycle_end;
  logic [7:0]   out_cnt;
  logic [7:0]   in_cnt;
  logic [31:0]  v;
  int           failures;
  int           cmp_count;
  int           n;
  logic [5:0]   ra [5] = '{`PSC_REG_CTRL, `PSC_REG_LIMIT, `PSC_REG_STATUS, `PSC_REG_UCNT, 6'h3c};
  logic [31:0]  rv [5] = '{32'h0, 32'hffff, 32'h0104_0000, 32'h0, 32'h0};

  psc_scan_seq dut (.clk, .rst_b, .bus_req, .rdata, .prog_start, .prog_done, .io,
    .svc_present, .svc_done, .svc_grant, .cycle_end);
  psc_far_model far (.clk, .rst_b, .prog_start, .prog_done, .io, .svc_grant, .svc_done,
    .out_cnt, .in_cnt);

  always #2.5 clk = ~clk;

  // ----------
  // tasks
  // ----------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return prog_start;
      1: return cycle_end;
      default: return svc_grant[0];
    endcase
  endfunction
  // bounded wait for a level, counting cycles
  task automatic wait_on(input int k, input logic lvl, input int lim, output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      #1;
      cyc++;
      if (cyc > lim) begin
        failures++;
        $display("wait ran out on signal %0d", k);
        report_and_stop();
      end
    end while (sig(k) !== lvl);
  endtask

  // ----------
  // sequence
  // ----------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    bus_req = '0;
    svc_present = 6'h01;
    failures = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (ra[i]) begin
      rd(ra[i], v);
      check("reset value", v, rv[i]);
    end
    wr(`PSC_REG_FIXED, 32'd27);
    rd(`PSC_REG_FIXED, v);
    check("fixed time", v, 32'd27);
    wr(`PSC_REG_UCNT, 32'h2);
    wr(`PSC_REG_UTIME, 32'h1);
    wr(`PSC_REG_CTRL, 32'h82);
    wait_on(0, 1'b1, 16 * TK, n);
    check("oversee span", 32'(n >= 12 * TK && n <= 15 * TK), 32'h1);
    @(posedge clk);
    wr(`PSC_REG_CTRL, 32'h02);
    wait_on(2, 1'b1, 20 * TK, n);
    wait_on(2, 1'b0, 12 * TK, n);
    check("service span", 32'(n >= 9 * TK && n <= 11 * TK), 32'h1);
    wait_on(1, 1'b1, 10 * TK, n);
    @(posedge clk);
    rd(`PSC_REG_STATUS, v);
    check("cycle time", 32'(v[15:0] >= 16'd26 && v[15:0] <= 16'd29), 32'h1);
    check("main idle", 32'(v[23:18]), 32'h1);
    rd(`PSC_REG_EXEC, v);
    check("exec time", 32'(v <= 32'h1), 32'h1);
    check("outputs", 32'(out_cnt), 32'h2);
    check("inputs", 32'(in_cnt), 32'h2);
    wr(`PSC_REG_CTRL, 32'h89);
    rd(`PSC_REG_STATUS, v);
    check("mode change state", 32'(v[27:18]), 32'h282);
    wait_on(2, 1'b1, 22 * TK, n);
    check("loop oversee", 32'(n >= 17 * TK && n <= 20 * TK), 32'h1);
    wait_on(2, 1'b0, 2 * TK, n);
    check("early slot end", 32'(n >= 100 && n < 200), 32'h1);
    report_and_stop();
  end
endmodule
